// >>> src/sbrg_pkg.sv
// package: register map, fields and divide factors of the baud generator
package sbrg_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [7:0] ADDR_BAUD_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RX_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_DIV_LOW   = 8'h08;
    localparam logic [7:0] ADDR_DIV_HIGH  = 8'h0C;
    localparam logic [7:0] ADDR_TX_CTRL   = 8'h10;
    // ==========================================================
    // field positions
    localparam int BIT_RX_IDLE    = 6;  // baud_control
    localparam int BIT_WIDE_SEL   = 3;  // baud_control
    localparam int BIT_CLK_MASTER = 7;  // transmit_status_control
    localparam int BIT_SYNC_MODE  = 4;  // transmit_status_control
    localparam int BIT_HIGH_SPEED = 2;  // transmit_status_control
    localparam int BIT_TX_EMPTY   = 1;  // transmit_status_control
    // writable bits and reset values
    localparam logic [7:0] BAUD_WMASK = 8'h1B;
    localparam logic [7:0] RX_WMASK   = 8'hF8;
    localparam logic [7:0] TX_WMASK   = 8'hFD;
    localparam logic [7:0] RST_BYTE   = 8'h00;
    // ==========================================================
    // prescale factors, held as factor minus one
    localparam logic [5:0] FACT_64 = 6'h3F;
    localparam logic [5:0] FACT_16 = 6'h0F;
    localparam logic [5:0] FACT_4  = 6'h03;
endpackage : sbrg_pkg

// >>> src/sbrg_top.sv
// baud rate generator with apb register access
// ==============================================================
// Summary of operation
// RQ1: one divider timer serves both modes, 8 or 16 bits, 8-bit after reset.
// RQ2: the wide divider select bit set makes the timer 16 bits, else 8.
// RQ3: the timer runs freely with its period set by the divisor pair.
// RQ4: in async mode the multiplier follows high speed and wide select.
// RQ5: in sync mode the high speed select bit is ignored.
// RQ6: any write to a divisor register clears the timer at once.
// RQ7: async, 8-bit, low speed gives fosc divided by 64 times n plus one.
// RQ8: async, 16-bit, low speed gives fosc divided by 16 times n plus one.
// RQ9: sync, 8-bit gives fosc divided by 4 times n plus one.
// RQ10: n is divisor_high as bits 15 to 8 and divisor_low as bits 7 to 0.
// RQ11: software checks the receiver idle flag before changing the clock.
// RQ12: async 8-bit high speed divides by 16, async 16-bit high speed by 4.
// RQ13: in 8-bit mode only divisor_low sets the period.
// RQ14: the mode bit set selects sync, clear selects async.
// RQ15: sync with clock master set derives the shift clock from the timer.
// RQ16: the receiver idle flag reads 1 when idle, 0 while receiving.
`timescale 1ns/1ns
module sbrg_top
    import sbrg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        rx_active,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             baud_tick,
    output logic             shift_clk_tick,
    output logic             sync_mode
);
    // ==========================================================
    // registers
    logic [7:0]  baud_control_reg;
    logic [7:0]  rx_ctrl_reg;
    logic [7:0]  divisor_low_reg;
    logic [7:0]  divisor_high_reg;
    logic [7:0]  tx_ctrl_reg;
    logic [5:0]  pre_reg;
    logic [15:0] timer_reg;
    logic [5:0]  factor;
    logic [15:0] limit;
    logic        wide_divider_sel;
    logic        high_speed_sel;
    logic        clock_master_sel;
    logic        pre_tick;
    logic        acc;
    logic        wr;
    logic        div_wr;
    logic        mapped;
    logic [7:0]  rd_byte;

    assign wide_divider_sel = baud_control_reg[BIT_WIDE_SEL];
    assign high_speed_sel   = tx_ctrl_reg[BIT_HIGH_SPEED];
    assign clock_master_sel = tx_ctrl_reg[BIT_CLK_MASTER];

    // ==========================================================
    // apb slave: one wait-free access phase, answer in cycle two
    assign acc    = psel & penable & pready;
    assign wr     = acc & pwrite & mapped;
    assign div_wr = wr & (paddr == ADDR_DIV_LOW || paddr == ADDR_DIV_HIGH);
    assign mapped = paddr == ADDR_BAUD_CTRL || paddr == ADDR_RX_CTRL ||
                    paddr == ADDR_DIV_LOW || paddr == ADDR_DIV_HIGH ||
                    paddr == ADDR_TX_CTRL;

    // read mux; idle flag is live, status bits read as fixed values
    always_comb begin
        rd_byte = RST_BYTE;
        case (paddr)
            ADDR_BAUD_CTRL: begin
                rd_byte = baud_control_reg;
                // RQ16 idle flag
                rd_byte[BIT_RX_IDLE] = ~rx_active;
            end
            ADDR_RX_CTRL:  rd_byte = rx_ctrl_reg;
            ADDR_DIV_LOW:  rd_byte = divisor_low_reg;
            ADDR_DIV_HIGH: rd_byte = divisor_high_reg;
            ADDR_TX_CTRL: begin
                rd_byte = tx_ctrl_reg;
                rd_byte[BIT_TX_EMPTY] = 1'b1; // no transmitter here
            end
            default:       rd_byte = RST_BYTE;
        endcase
    end

    // ready rises in the first access cycle, data and error with it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel & ~penable) begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ==========================================================
    // control register writes, reserved and status bits masked off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // RQ1 starts 8-bit
            baud_control_reg <= RST_BYTE;
            rx_ctrl_reg      <= RST_BYTE;
            tx_ctrl_reg      <= RST_BYTE;
        end else if (wr) begin
            if (paddr == ADDR_BAUD_CTRL) begin
                baud_control_reg <= pwdata[7:0] & BAUD_WMASK;
            end
            if (paddr == ADDR_RX_CTRL) begin
                rx_ctrl_reg <= pwdata[7:0] & RX_WMASK;
            end
            if (paddr == ADDR_TX_CTRL) begin
                tx_ctrl_reg <= pwdata[7:0] & TX_WMASK;
            end
        end
    end

    // divisor pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divisor_low_reg  <= RST_BYTE;
            divisor_high_reg <= RST_BYTE;
        end else if (wr) begin
            if (paddr == ADDR_DIV_LOW) begin
                divisor_low_reg <= pwdata[7:0];
            end
            if (paddr == ADDR_DIV_HIGH) begin
                divisor_high_reg <= pwdata[7:0];
            end
        end
    end

    // ==========================================================
    // divide factor select
    always_comb begin
        // RQ14 mode picks table
        if (sync_mode) begin
            // RQ5 high speed ignored; RQ9 sync divides by 4
            factor = FACT_4;
        end else begin
            // RQ4 async uses both bits
            case ({wide_divider_sel, high_speed_sel})
                // RQ7 divide by 64
                2'b00:   factor = FACT_64;
                // RQ8 and RQ12 divide by 16
                2'b01:   factor = FACT_16;
                2'b10:   factor = FACT_16;
                default: factor = FACT_4;
            endcase
        end
    end

    // period limit; high byte only counts in 16-bit mode
    always_comb begin
        // RQ2 and RQ10 wide divisor
        if (wide_divider_sel) begin
            limit = {divisor_high_reg, divisor_low_reg};
        end else begin
            // RQ13 low byte only
            limit = {8'h00, divisor_low_reg};
        end
    end

    assign pre_tick = pre_reg == factor;

    // prescaler; a divisor write restarts it so the first period is full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 6'h00;
        end else if (div_wr || pre_tick) begin
            // RQ6 clear on write
            pre_reg <= 6'h00;
        end else begin
            pre_reg <= pre_reg + 6'h01;
        end
    end

    // free running divider timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_reg <= 16'h0000;
        end else if (div_wr) begin
            // RQ6 clear on write
            timer_reg <= 16'h0000;
        end else if (pre_tick) begin
            // RQ3 runs continuously
            timer_reg <= (timer_reg >= limit) ? 16'h0000
                                              : timer_reg + 16'h0001;
        end
    end

    // ==========================================================
    // outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_tick      <= 1'b0;
            shift_clk_tick <= 1'b0;
            sync_mode      <= 1'b0;
        end else begin
            baud_tick <= pre_tick & (timer_reg >= limit) & ~div_wr;
            // RQ15 master shift clock
            shift_clk_tick <= pre_tick & (timer_reg >= limit) & ~div_wr &
                              sync_mode & clock_master_sel;
            sync_mode <= tx_ctrl_reg[BIT_SYNC_MODE];
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_div_write;
        div_wr;
    endsequence
    sequence s_period_end;
        pre_tick && timer_reg >= limit && !div_wr;
    endsequence

    property p_wide_by_write;
        $changed(wide_divider_sel) |-> $past(wr) &&
            $past(paddr) == ADDR_BAUD_CTRL;
    endproperty
    a_wide_by_write: assert property (p_wide_by_write) // RQ1
        else $error("wide select changed without a write");

    property p_tick_at_end;
        s_period_end |=> baud_tick ##1 !baud_tick;
    endproperty
    a_tick_at_end: assert property (p_tick_at_end) // RQ2
        else $error("baud tick missing at period end");

    property p_timer_runs;
        (pre_tick && timer_reg < limit && !div_wr) |=>
            timer_reg == $past(timer_reg) + 16'h0001;
    endproperty
    a_timer_runs: assert property (p_timer_runs) // RQ3
        else $error("timer did not advance");

    // prescaler must wrap after four cycles, not merely select a factor
    property p_async_fast_wide;
        (!sync_mode && wide_divider_sel && high_speed_sel &&
            pre_reg == FACT_4 && !div_wr) |=> pre_reg == 6'h00;
    endproperty
    a_async_fast_wide: assert property (p_async_fast_wide) // RQ4
        else $error("async wide fast factor wrong");

    property p_sync_factor;
        (sync_mode && pre_reg == FACT_4 && !div_wr) |=> pre_reg == 6'h00;
    endproperty
    a_sync_factor: assert property (p_sync_factor) // RQ5
        else $error("sync factor wrong");

    property p_write_clears;
        s_div_write |=> timer_reg == 16'h0000 && pre_reg == 6'h00
            ##1 !baud_tick;
    endproperty
    a_write_clears: assert property (p_write_clears) // RQ6
        else $error("divisor write did not clear timer");

    property p_async_slow_narrow;
        (!sync_mode && !wide_divider_sel && !high_speed_sel &&
            pre_reg == FACT_64 && !div_wr) |=> pre_reg == 6'h00;
    endproperty
    a_async_slow_narrow: assert property (p_async_slow_narrow) // RQ7
        else $error("async 8-bit slow factor wrong");

    property p_async_slow_wide;
        (!sync_mode && wide_divider_sel && !high_speed_sel &&
            pre_reg == FACT_16 && !div_wr) |=> pre_reg == 6'h00;
    endproperty
    a_async_slow_wide: assert property (p_async_slow_wide) // RQ8
        else $error("async 16-bit slow factor wrong");

    // in 8-bit mode the timer wraps at the low byte whatever the high byte holds
    property p_narrow_limit;
        (!wide_divider_sel && pre_tick && !div_wr &&
            timer_reg == {8'h00, divisor_low_reg}) |=>
            timer_reg == 16'h0000;
    endproperty
    a_narrow_limit: assert property (p_narrow_limit) // RQ13
        else $error("8-bit mode used high divisor");

    property p_shift_clk;
        shift_clk_tick |-> baud_tick && $past(sync_mode) &&
            $past(clock_master_sel);
    endproperty
    a_shift_clk: assert property (p_shift_clk) // RQ15
        else $error("shift clock outside sync master");

    property p_idle_read;
        (psel && !penable && !pwrite && paddr == ADDR_BAUD_CTRL) |=>
            prdata[BIT_RX_IDLE] == !$past(rx_active);
    endproperty
    a_idle_read: assert property (p_idle_read) // RQ16
        else $error("idle flag read wrong");

endmodule : sbrg_top

// >>> tb/tb_serial_baud_rate_generator.sv
// self-checking testbench of the baud rate generator over apb
`timescale 1ns/1ns
module tb_serial_baud_rate_generator
    import sbrg_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, rx_active;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, baud_tick, shift_clk_tick, sync_mode;
    int          num_errors, checks_done, cycles;

    sbrg_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .rx_active(rx_active), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .baud_tick(baud_tick),
        .shift_clk_tick(shift_clk_tick), .sync_mode(sync_mode));

    // ==========================================================
    // clock, and a cycle ceiling well above the longest period pair
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: cycle ceiling reached", $time);
            end_sim();
        end
    end

    // ==========================================================
    // shared helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: %s got %h", $time, msg, got);
        end
    endtask : check

    // pready is registered, so the value seen at a rising edge is the
    // one that edge samples; data are taken and released only there
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a;
        pwrite <= w; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 20) check(32'h0, 32'h1, "no pready");
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, {24'h000000, d}, r, e);
        check({31'h0, e}, 32'h0, "write error flag");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 32'h0, r, e);
        check(r, exp, "read data");
        check({31'h0, e}, {31'h0, exp_err}, "read error flag");
    endtask : rd

    // cycles until the next baud tick, checking the shift tick there
    task automatic next_tick(input logic master, output int n);
        n = 0;
        do begin
            @(negedge pclk);
            n = n + 1;
        end while (baud_tick !== 1'b1 && n < 5000);
        check({31'h0, shift_clk_tick}, {31'h0, master}, "shift tick");
    endtask : next_tick

    // ==========================================================
    // scenarios
    task automatic reset_values();
        rd(ADDR_BAUD_CTRL, 32'h00000040, 1'b0);
        rd(ADDR_RX_CTRL, 32'h0, 1'b0);
        rd(ADDR_DIV_LOW, 32'h0, 1'b0);
        rd(ADDR_DIV_HIGH, 32'h0, 1'b0);
        rd(ADDR_TX_CTRL, 32'h00000002, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
    endtask : reset_values

    task automatic access_kinds();
        wr(ADDR_BAUD_CTRL, 8'hFF);
        wr(ADDR_RX_CTRL, 8'hFF);
        wr(ADDR_DIV_LOW, 8'hFF);
        wr(ADDR_DIV_HIGH, 8'hFF);
        wr(ADDR_TX_CTRL, 8'hFF);
        rd(ADDR_BAUD_CTRL, 32'h0000005B, 1'b0);
        rd(ADDR_RX_CTRL, 32'h000000F8, 1'b0);
        rd(ADDR_DIV_LOW, 32'h000000FF, 1'b0);
        rd(ADDR_DIV_HIGH, 32'h000000FF, 1'b0);
        rd(ADDR_TX_CTRL, 32'h000000FF, 1'b0);
        @(posedge pclk) rx_active <= 1'b1;
        rd(ADDR_BAUD_CTRL, 32'h0000001B, 1'b0);
        @(posedge pclk) rx_active <= 1'b0;
        wr(ADDR_TX_CTRL, 8'h00);
        wr(ADDR_BAUD_CTRL, 8'h00);
    endtask : access_kinds

    // set mode, then divisor high 1 and low 2; the low write restarts
    task automatic rate(input logic [7:0] tx, input logic [7:0] bc,
                        input int exp);
        int first, gap;
        wr(ADDR_TX_CTRL, tx);
        wr(ADDR_BAUD_CTRL, bc);
        rd(ADDR_BAUD_CTRL, {24'h000000, (bc & BAUD_WMASK) | 8'h40}, 1'b0);
        wr(ADDR_DIV_HIGH, 8'h01);
        wr(ADDR_DIV_LOW, 8'h02);
        check({31'h0, sync_mode}, {31'h0, tx[4]}, "mode level");
        next_tick(tx[7] & tx[4], first);
        check(first, exp + 1, "restart delay");
        next_tick(tx[7] & tx[4], gap);
        check(gap, exp, "baud period");
    endtask : rate

    task automatic all_rates();
        rate(8'h00, 8'h00, 192);
        rate(8'h04, 8'h00, 48);
        rate(8'h00, 8'h08, 4144);
        rate(8'h04, 8'h08, 1036);
        rate(8'h94, 8'h00, 12);
        rate(8'h10, 8'h00, 12);
        rate(8'h90, 8'h08, 1036);
    endtask : all_rates

    // ==========================================================
    // verdict, reached from the main sequence or the ceiling
    task automatic end_sim();
        $display("checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    initial begin
        num_errors = 0; checks_done = 0; cycles = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; rx_active = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        access_kinds();
        all_rates();
        end_sim();
    end
endmodule : tb_serial_baud_rate_generator
